// ### core/pfpg_decode.sv
// Program address to partition decoder
`timescale 1ns/1ps
module pfpg_decode #(
  parameter int FLASH_KB = 128
) (
  // Address
  input wire logic [pfpg_pkg::PC_W-1:0] addr,
  // Configuration
  input wire logic boot_part_enable_n,
  input wire logic storage_part_enable_n,
  input wire logic [pfpg_pkg::BOOT_SIZE_W-1:0] boot_part_size,
  // Result
  output pfpg_pkg::pfpg_part_e part
);
  import pfpg_pkg::*;
  localparam logic [PC_W-1:0] FLASH_WORDS = PC_W'(FLASH_KB * 512);
  logic [PC_W-1:0] boot_words;
  logic [PC_W-1:0] store_base;
  assign boot_words = BOOT_BASE_WORDS << boot_part_size;
  assign store_base = FLASH_WORDS - STORAGE_WORDS;
  always_comb
  begin
    if (addr >= FLASH_WORDS)
      part = PFPG_P_NONE;
    else if (!storage_part_enable_n && addr >= store_base)
      part = PFPG_P_STORE;
    else if (!boot_part_enable_n && addr < boot_words)
      part = PFPG_P_BOOT;
    else
      part = PFPG_P_APP;
  end
endmodule : pfpg_decode

// ### core/pfpg_guard.sv
// Program flash partition guard: fetch filter, write protection, status
//
// Notes on behaviour
// - Program addresses are 21 bits wide, spanning 2M 16-bit words (4 Mbyte).
// - Fetches and reads beyond implemented flash return an all-zero word.
// - Implemented flash is 32, 64 or 128 KB, set by a build parameter.
// - After reset the fetch program counter starts at address zero.
// - With both enables at one, all flash is application space.
// - The application write protect blocks writes to application space.
// - The boot block exists only when enabled; its size comes from a field.
// - Boot code may be fetched; boot has protection of its own.
// - The boot write protect blocks writes to the boot block.
// - An enabled storage area occupies the last 128 words of flash.
// - Fetches from an enabled storage area are refused.
// - The storage write protect blocks writes to the storage area.
// - A protected write leaves memory unchanged and sets the write error flag.
// - Fetch and data paths are separate ports that work in the same cycle.
// - Reads of unmapped register addresses return zero.
`timescale 1ns/1ps
module pfpg_guard #(
  parameter int FLASH_KB = 128
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Configuration
  input wire logic boot_part_enable_n,
  input wire logic storage_part_enable_n,
  input wire logic app_write_protect,
  input wire logic boot_write_protect,
  input wire logic storage_write_protect,
  input wire logic [pfpg_pkg::BOOT_SIZE_W-1:0] boot_part_size,
  // CPU fetch path
  input wire logic fetch_advance,
  input wire logic fetch_jump,
  input wire logic [pfpg_pkg::PC_W-1:0] fetch_target,
  output logic [pfpg_pkg::PC_W-1:0] fetch_pc,
  output logic [pfpg_pkg::DATA_W-1:0] fetch_word,
  output logic fetch_refused,
  // Flash array read port
  output logic [pfpg_pkg::PC_W-1:0] flash_fetch_addr,
  input wire logic [pfpg_pkg::DATA_W-1:0] flash_fetch_data,
  output logic [pfpg_pkg::PC_W-1:0] flash_rd_addr,
  input wire logic [pfpg_pkg::DATA_W-1:0] flash_rd_data,
  // NVM controller requests
  input wire logic nvm_rd_req,
  input wire logic [pfpg_pkg::PC_W-1:0] nvm_rd_addr,
  output logic [pfpg_pkg::DATA_W-1:0] nvm_rd_data,
  input wire logic nvm_wr_req,
  input wire logic [pfpg_pkg::PC_W-1:0] nvm_wr_addr,
  input wire logic [pfpg_pkg::DATA_W-1:0] nvm_wr_data,
  // Flash array write port
  output logic flash_wr_en,
  output logic [pfpg_pkg::PC_W-1:0] flash_wr_addr,
  output logic [pfpg_pkg::DATA_W-1:0] flash_wr_data,
  output logic nv_write_error_flag,
  // Avalon-MM slave
  input wire logic [pfpg_pkg::AV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq
);
  import pfpg_pkg::*;

  // =====================================================
  // Partition decode, fetch and data sides in parallel
  pfpg_part_e fetch_part;
  pfpg_part_e rd_part;
  pfpg_part_e wr_part;
  logic [PC_W-1:0] fetch_pc_ff;
  logic [PC_W-1:0] nxt_fetch_pc;

  pfpg_decode #(.FLASH_KB(FLASH_KB)) u_dec_fetch (
    .addr(fetch_pc_ff),
    .boot_part_enable_n(boot_part_enable_n),
    .storage_part_enable_n(storage_part_enable_n),
    .boot_part_size(boot_part_size),
    .part(fetch_part)
  );
  pfpg_decode #(.FLASH_KB(FLASH_KB)) u_dec_rd (
    .addr(nvm_rd_addr),
    .boot_part_enable_n(boot_part_enable_n),
    .storage_part_enable_n(storage_part_enable_n),
    .boot_part_size(boot_part_size),
    .part(rd_part)
  );
  pfpg_decode #(.FLASH_KB(FLASH_KB)) u_dec_wr (
    .addr(nvm_wr_addr),
    .boot_part_enable_n(boot_part_enable_n),
    .storage_part_enable_n(storage_part_enable_n),
    .boot_part_size(boot_part_size),
    .part(wr_part)
  );

  // =====================================================
  // Program counter
  always_comb
  begin
    if (fetch_jump)
      nxt_fetch_pc = fetch_target;
    else if (fetch_advance)
      nxt_fetch_pc = fetch_pc_ff + PC_W'(1);
    else
      nxt_fetch_pc = fetch_pc_ff;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      fetch_pc_ff <= RESET_VECTOR;
    else
      fetch_pc_ff <= nxt_fetch_pc;
  end

  assign fetch_pc = fetch_pc_ff;
  assign flash_fetch_addr = fetch_pc_ff;
  assign flash_rd_addr = nvm_rd_addr;

  // =====================================================
  // Fetch filter: zero word outside flash or from storage
  logic fetch_blocked;
  logic fetch_void;
  assign fetch_blocked = (fetch_part == PFPG_P_STORE);
  assign fetch_void = (fetch_part == PFPG_P_NONE);
  assign fetch_refused = fetch_blocked;

  always_comb
  begin
    if (fetch_void || fetch_blocked)
      fetch_word = ZERO_WORD;
    else
      fetch_word = flash_fetch_data;
  end

  // =====================================================
  // Data read path, one cycle behind the request
  logic [DATA_W-1:0] rd_data_ff;
  logic [DATA_W-1:0] nxt_rd_data;

  always_comb
  begin
    if (!nvm_rd_req || rd_part == PFPG_P_NONE)
      nxt_rd_data = ZERO_WORD;
    else
      nxt_rd_data = flash_rd_data;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rd_data_ff <= ZERO_WORD;
    else
      rd_data_ff <= nxt_rd_data;
  end

  assign nvm_rd_data = rd_data_ff;

  // =====================================================
  // Write protection
  logic wr_protected;
  always_comb
  begin
    unique case (wr_part)
      PFPG_P_APP: wr_protected = app_write_protect;
      PFPG_P_BOOT: wr_protected = boot_write_protect;
      PFPG_P_STORE: wr_protected = storage_write_protect;
      default: wr_protected = 1'b1;
    endcase
  end

  logic wr_err_evt;
  logic wr_allowed;

  assign wr_err_evt = nvm_wr_req && wr_protected;
  assign wr_allowed = nvm_wr_req && !wr_protected;

  // =====================================================
  // Flash write port, one cycle behind an allowed request
  logic flash_wr_en_ff;
  logic [PC_W-1:0] flash_wr_addr_ff;
  logic [DATA_W-1:0] flash_wr_data_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      flash_wr_en_ff <= 1'b0;
    else
      flash_wr_en_ff <= wr_allowed;
  end

  // Refused data never reaches the array port
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      flash_wr_addr_ff <= '0;
      flash_wr_data_ff <= '0;
    end
    else if (wr_allowed)
    begin
      flash_wr_addr_ff <= nvm_wr_addr;
      flash_wr_data_ff <= nvm_wr_data;
    end
  end

  assign flash_wr_en = flash_wr_en_ff;
  assign flash_wr_addr = flash_wr_addr_ff;
  assign flash_wr_data = flash_wr_data_ff;

  // =====================================================
  // Status events, one sticky bit each
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] status_ff;
  logic [EV_W-1:0] nxt_status;
  logic [EV_W-1:0] rd_clear;
  logic rd_take;
  logic wr_take;

  assign events[ST_NV_WRITE_ERROR_FLAG] = wr_err_evt;
  assign events[ST_FETCH] = fetch_blocked && fetch_advance;

  for (genvar i = 0; i < EV_W; i++)
  begin : g_status
    // Set wins over a clear in the same cycle
    assign nxt_status[i] = events[i] || (status_ff[i] && !rd_clear[i]);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      status_ff <= '0;
    else
      status_ff <= nxt_status;
  end

  assign nv_write_error_flag = status_ff[ST_NV_WRITE_ERROR_FLAG];

  // =====================================================
  // Interrupt mask
  logic [EV_W-1:0] mask_ff;
  logic [EV_W-1:0] nxt_mask;

  always_comb
  begin
    if (wr_take && avs_address == REG_MASK)
      nxt_mask = avs_writedata[EV_W-1:0];
    else
      nxt_mask = mask_ff;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      mask_ff <= MASK_RESET;
    else
      mask_ff <= nxt_mask;
  end

  assign irq = |(status_ff & mask_ff);

  // =====================================================
  // Bus slave: a wait cycle loads the read word, then the answer
  typedef enum logic [1:0] {
    PFPG_BUS_IDLE = 2'b01,
    PFPG_BUS_ANSWER = 2'b10
  } pfpg_bus_e;

  pfpg_bus_e bus_state_ff;
  pfpg_bus_e nxt_bus_state;
  logic bus_req;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;

  assign bus_req = avs_read || avs_write;

  always_comb
  begin
    nxt_bus_state = PFPG_BUS_IDLE;
    unique case (bus_state_ff)
      PFPG_BUS_IDLE: nxt_bus_state = bus_req ? PFPG_BUS_ANSWER : PFPG_BUS_IDLE;
      PFPG_BUS_ANSWER: nxt_bus_state = PFPG_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      bus_state_ff <= PFPG_BUS_IDLE;
    else
      bus_state_ff <= nxt_bus_state;
  end

  assign avs_waitrequest = bus_req && bus_state_ff == PFPG_BUS_IDLE;
  assign rd_take = avs_read && bus_state_ff == PFPG_BUS_ANSWER;
  assign wr_take = avs_write && bus_state_ff == PFPG_BUS_ANSWER;

  always_comb
  begin
    unique case (avs_address)
      REG_STATUS: nxt_readdata = {30'h0, status_ff};
      REG_MASK: nxt_readdata = {30'h0, mask_ff};
      REG_PART: nxt_readdata = {28'h0, fetch_part};
      default: nxt_readdata = 32'h0;
    endcase
  end

  // Loaded in the wait cycle, held through the answer
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      readdata_ff <= 32'h0;
    else if (avs_read && bus_state_ff == PFPG_BUS_IDLE)
      readdata_ff <= nxt_readdata;
  end

  assign avs_readdata = readdata_ff;

  // A status read clears only the bits it returned
  assign rd_clear = (rd_take && avs_address == REG_STATUS) ? readdata_ff[EV_W-1:0] : '0;

endmodule : pfpg_guard

// ### core/pfpg_pkg.sv
// Constants and types for the program flash partition guard
package pfpg_pkg;
  // =====================================================
  // Address space
  localparam int PC_W = 21;
  localparam int DATA_W = 16;
  localparam int DADDR_W = 14;
  localparam logic [PC_W-1:0] RESET_VECTOR = 21'h000000;
  localparam logic [PC_W-1:0] STORAGE_WORDS = 21'h000080;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  // =====================================================
  // Flash size selections in kilobytes
  localparam int FLASH_KB_SMALL = 32;
  localparam int FLASH_KB_MID = 64;
  localparam int FLASH_KB_LARGE = 128;
  // =====================================================
  // Boot size field: size in words is BOOT_BASE_WORDS << field
  localparam int BOOT_SIZE_W = 3;
  localparam logic [PC_W-1:0] BOOT_BASE_WORDS = 21'h000200;
  // =====================================================
  // Bus slave register map (word aligned byte addresses)
  localparam int AV_ADDR_W = 4;
  localparam logic [AV_ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [AV_ADDR_W-1:0] REG_MASK = 4'h4;
  localparam logic [AV_ADDR_W-1:0] REG_PART = 4'h8;
  localparam int ST_NV_WRITE_ERROR_FLAG = 0;
  localparam int ST_FETCH = 1;
  localparam int EV_W = 2;
  localparam logic [EV_W-1:0] MASK_RESET = 2'h0;
  // =====================================================
  // Partition codes
  typedef enum logic [3:0] {
    PFPG_P_NONE = 4'h1,
    PFPG_P_APP = 4'h2,
    PFPG_P_BOOT = 4'h4,
    PFPG_P_STORE = 4'h8
  } pfpg_part_e;
endpackage : pfpg_pkg

// ### verification/pfpg_flash_model.sv
// Flash array model behind the guard's read ports
`timescale 1ns/1ps
module pfpg_flash_model (
  // Read ports
  input wire logic [20:0] flash_fetch_addr,
  output logic [15:0] flash_fetch_data,
  input wire logic [20:0] flash_rd_addr,
  output logic [15:0] flash_rd_data
);
  // Each word holds an address pattern
  assign flash_fetch_data = flash_fetch_addr[15:0] ^ 16'ha5c3;
  assign flash_rd_data = flash_rd_addr[15:0] ^ 16'ha5c3;
endmodule : pfpg_flash_model

// ### verification/pfpg_guard_props.sv
// Checker on the partition guard ports
`timescale 1ns/1ps
module pfpg_guard_props #(
  parameter int FLASH_KB = 128
) (
  // Clock, reset, configuration
  input wire logic clock,
  input wire logic nrst,
  input wire logic boot_part_enable_n,
  input wire logic storage_part_enable_n,
  input wire logic app_write_protect,
  input wire logic boot_write_protect,
  input wire logic storage_write_protect,
  input wire logic [2:0] boot_part_size,
  // Fetch and write paths
  input wire logic fetch_jump,
  input wire logic [20:0] fetch_target,
  input wire logic [20:0] fetch_pc,
  input wire logic [15:0] fetch_word,
  input wire logic fetch_refused,
  input wire logic nvm_wr_req,
  input wire logic [20:0] nvm_wr_addr,
  input wire logic flash_wr_en,
  input wire logic [20:0] flash_wr_addr,
  input wire logic nv_write_error_flag
);
  localparam int W = FLASH_KB * 512;
  logic [20:0] a;
  logic st;
  assign a = nvm_wr_addr;
  assign st = !storage_part_enable_n && a >= W - 128 && a < W;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ==========
  // Properties
  sequence s_err; nv_write_error_flag && !flash_wr_en; endsequence
  property p_start; $rose(nrst) |-> fetch_pc == 0; endproperty
  property p_jump; fetch_jump |=> fetch_pc == $past(fetch_target); endproperty
  property p_beyond; fetch_pc >= W |-> fetch_word == 0 && !fetch_refused; endproperty
  property p_refuse;
    fetch_refused == (!storage_part_enable_n && fetch_pc >= W - 128 && fetch_pc < W);
  endproperty
  property p_range; nvm_wr_req && a >= W |=> s_err; endproperty
  property p_app;
    nvm_wr_req && app_write_protect && boot_part_enable_n && !st && a < W |=> s_err;
  endproperty
  property p_boot;
    nvm_wr_req && !boot_part_enable_n && boot_write_protect && !st && a < W
      && a < (21'h200 << boot_part_size) |=> s_err;
  endproperty
  property p_store; nvm_wr_req && st && storage_write_protect |=> s_err; endproperty
  property p_pass;
    nvm_wr_req && boot_part_enable_n && storage_part_enable_n && !app_write_protect
      && a < W |=> flash_wr_en && flash_wr_addr == $past(a);
  endproperty
  a_start: assert property (p_start) else $error("pc not zero");
  a_jump: assert property (p_jump) else $error("jump lost");
  a_beyond: assert property (p_beyond) else $error("word not zero");
  a_refuse: assert property (p_refuse) else $error("refuse wrong");
  a_range: assert property (p_range) else $error("range write");
  a_app: assert property (p_app) else $error("app write");
  a_boot: assert property (p_boot) else $error("boot write");
  a_store: assert property (p_store) else $error("store write");
  a_pass: assert property (p_pass) else $error("write lost");
  c_refuse: cover property (fetch_refused);
  c_err: cover property (nv_write_error_flag);
  c_wr: cover property (flash_wr_en);
endmodule : pfpg_guard_props
bind pfpg_guard pfpg_guard_props #(.FLASH_KB(FLASH_KB)) i_props (.*);

// ### verification/pfpg_guard_tb.sv
// Self-checking bench for the partition guard
`timescale 1ns/1ps
module pfpg_guard_tb;
  import pfpg_pkg::*;
  // ==========
  // Signals
  logic clock = 0, nrst = 0, fetch_advance = 0, fetch_jump = 0, nvm_rd_req = 0;
  logic nvm_wr_req = 0, avs_read = 0, avs_write = 0;
  logic [7:0] cfg = 8'hc0;
  logic [20:0] fetch_target = 0, nvm_rd_addr = 0, nvm_wr_addr = 0, a;
  logic [15:0] nvm_wr_data = 0;
  logic [3:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata;
  wire boot_part_enable_n, storage_part_enable_n, app_write_protect, boot_write_protect;
  wire storage_write_protect, fetch_refused, flash_wr_en, nv_write_error_flag;
  wire avs_waitrequest, irq;
  wire [2:0] boot_part_size;
  wire [20:0] fetch_pc, flash_fetch_addr, flash_rd_addr, flash_wr_addr;
  wire [15:0] fetch_word, flash_fetch_data, flash_rd_data, nvm_rd_data, flash_wr_data;
  logic [36:0] exq[$];
  logic [34:0] t;
  int n_errors = 0, checks = 0, cyc = 0, seed = 32'hfbfb;
  // Fetch: config, address, beyond, refused, partition
  localparam logic [34:0] FT[8] = '{{8'hc0, 21'h0, 6'h02},
    {8'h40, 21'h1ff, 6'h04}, {8'h41, 21'h3ff, 6'h04},
    {8'h40, 21'h200, 6'h02}, {8'h80, 21'hff80, 6'h18},
    {8'h80, 21'hff7f, 6'h02}, {8'hc0, 21'h10000, 6'h21},
    {8'hc0, 21'h1fffff, 6'h21}};
  // Write: config, address, allowed
  localparam logic [29:0] WT[8] = '{{8'he0, 21'h1234, 1'b0},
    {8'h60, 21'h100, 1'b1}, {8'h50, 21'h1ff, 1'b0}, {8'h50, 21'h200, 1'b1},
    {8'h51, 21'h3ff, 1'b0}, {8'h88, 21'hff80, 1'b0},
    {8'h88, 21'hff7f, 1'b1}, {8'hc0, 21'h10000, 1'b0}};
  assign {boot_part_enable_n, storage_part_enable_n, app_write_protect, boot_write_protect,
    storage_write_protect, boot_part_size} = cfg;
  pfpg_guard i_dut (.*);
  pfpg_flash_model i_flash (.*);
  always #10 clock = ~clock;
  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clock);
  endtask : bus
  task automatic rd(input logic [3:0] ad, input logic [31:0] e);
    exq.push_back(37'(e));
    bus(0, ad, 0);
  endtask : rd
  task automatic nvw(input logic [20:0] wa, input logic ok);
    logic [15:0] d;
    d = 16'($random(seed));
    if (ok)
      exq.push_back({wa, d});
    nvm_wr_req <= 1;
    nvm_wr_addr <= wa;
    nvm_wr_data <= d;
    @(posedge clock);
    nvm_wr_req <= 0;
    @(posedge clock);
    @(negedge clock);
    chk(nv_write_error_flag, !ok);
    chk(irq, !ok);
    @(posedge clock);
    rd(REG_STATUS, !ok);
    chk(irq, 0);
  endtask : nvw
  // Results seen on the outputs
  always @(posedge clock)
  begin
    if (avs_read && !avs_waitrequest)
      chk(avs_readdata, exq.size() ? exq.pop_front() : 'x);
    if (flash_wr_en)
      chk({flash_wr_addr, flash_wr_data}, exq.size() ? exq.pop_front() : 'x);
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    repeat (3) @(posedge clock);
    nrst <= 1;
    @(negedge clock);
    chk(fetch_word, 16'ha5c3);
    @(posedge clock);
    rd(REG_MASK, 0);
    rd(4'hc, 0);
    foreach (FT[i])
    begin
      t = FT[i];
      a = t[26:6];
      cfg <= t[34:27];
      fetch_jump <= 1;
      fetch_target <= a;
      nvm_rd_req <= 1;
      nvm_rd_addr <= a ^ 21'h1;
      @(posedge clock);
      fetch_jump <= 0;
      @(negedge clock);
      chk(fetch_pc, a);
      chk(fetch_word, t[5] | t[4] ? 16'h0 : a[15:0] ^ 16'ha5c3);
      chk(fetch_refused, t[4]);
      chk(nvm_rd_data, t[5] ? 16'h0 : a[15:0] ^ 16'ha5c2);
      @(posedge clock);
      rd(REG_PART, t[3:0]);
    end
    cfg <= 8'h80;
    fetch_jump <= 1;
    fetch_target <= 21'hff80;
    @(posedge clock);
    fetch_jump <= 0;
    fetch_advance <= 1;
    @(posedge clock);
    fetch_advance <= 0;
    @(negedge clock);
    chk(fetch_pc, 21'hff81);
    chk(irq, 0);
    @(posedge clock);
    rd(REG_STATUS, 2);
    cfg <= 8'hc0;
    bus(1, REG_MASK, 1);
    repeat (3)
      nvw(21'($random(seed)) & 21'hffff, 1);
    foreach (WT[i])
    begin
      cfg <= WT[i][29:22];
      nvw(WT[i][21:1], WT[i][0]);
    end
    results();
  end
endmodule : pfpg_guard_tb
